// >>> pkg/twfg_defs.vh
// Constants for the traverse winding frequency generator
`ifndef TWFG_DEFS_VH
`define TWFG_DEFS_VH
// Control select codes
`define TWFG_CTRL_OFF 2'h0
`define TWFG_CTRL_SETF 2'h1
`define TWFG_CTRL_MAXF 2'h2
// Operation select bits
`define TWFG_OP_TWOPT_BIT 0
`define TWFG_OP_RAND_BIT 1
// Pulse source code for pulse-train input
`define TWFG_PSRC_PULSE 2'h2
// Switch function code for length counting
`define TWFG_SWFN_LENGTH 8'h0E
// Percent scale in 0.1 percent units
`define TWFG_PCT_FULL 32'h000003E8
// Clock rate and tick period
`define TWFG_CLK_HZ 32'h02FA_F080
`define TWFG_TICK_HZ 32'h0000_03E8
`define TWFG_TICK_CYC (`TWFG_CLK_HZ / `TWFG_TICK_HZ)
// Length counter pulses per metre
`define TWFG_PULSES_PER_M 32'h0000_0001
// Register offsets
`define TWFG_REG_CTRL 8'h00
`define TWFG_REG_AMP 8'h04
`define TWFG_REG_CYCLE 8'h08
`define TWFG_REG_PULSE 8'h0C
`define TWFG_REG_BIAS 8'h10
`define TWFG_REG_RAND 8'h14
`define TWFG_REG_LEN 8'h18
`define TWFG_REG_FREQ 8'h1C
`define TWFG_REG_LIMIT 8'h20
`define TWFG_REG_OUTF 8'h24
`define TWFG_REG_LENST 8'h28
`define TWFG_REG_DISP 8'h2C
// Reset values
`define TWFG_RST_FILT 8'h0A
`define TWFG_RST_RATE 16'h2710
`endif

// >>> src/twfg_traverse_winding_freq_gen.v
// Traverse winding frequency generator with pulse-train frequency input
// Contract
// - Control 1: amplitude is setting frequency times amplitude percent.
// - Control 2: amplitude is maximum frequency times amplitude percent.
// - Recoil step is a percentage of the swing amplitude.
// - Rise ramp lasts cycle time times rise coefficient.
// - Fall ramp lasts cycle time times hundred minus rise coefficient.
// - Pulse source 2: full-scale pulse rate maps to maximum frequency.
// - Pulse frequency gets bias and gain relative to maximum frequency.
// - Pulse frequency clamped to maximum, upper and lower limits.
// - Negative pulse frequency never reverses rotation.
// - Pulse input filtered over 10 to 100 samples.
// - Random modes vary each rise time between max and min bounds; the code uses the rise coefficient for the first rise after start.
// - Two-point modes move base toward second speed with length.
// - Mode 3 combines two-point movement and random rise ratio.
// - Random rise bounds are 0.0 to 100.0 percent.
// - Switch function 14 counts switch pulses times multiplier as length.
// - Winding stops once counted length reaches stop length.
// - Stop length zero disables length-based stopping.
// - Stop length display scaled by range with decimal point position.
// - Control select 0 disables the swing.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "twfg_defs.vh"
module twfg_traverse_winding_freq_gen
(
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Pulse and switch inputs
  input wire pulseIn,
  input wire firstInputSwitch,
  // AXI4-Lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Frequency outputs in 0.01 Hz units
  output wire [15:0] windFreqOut,
  output wire [15:0] pulseFreqOut,
  output wire windingActive
);
  // ****************************************************
  // Functions
  // ****************************************************
  // Value times percent in 0.1 percent units
  function [15:0] pctOf;
    input [15:0] val;
    input [9:0] pct;
    reg [25:0] p;
    begin
      p = val * pct;
      p = p / 26'h00003E8;
      pctOf = p[15:0];
    end
  endfunction
  // Whole percent, capped at 100, into 0.1 percent units
  function [9:0] tenths;
    input [7:0] whole;
    begin
      tenths = (whole > 8'h64) ? 10'h3E8 : {2'b00, whole} * 10'h00A;
    end
  endfunction
  function [31:0] mergeStrb;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      mergeStrb = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i])
          mergeStrb[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction
  // ****************************************************
  // Registers
  // ****************************************************
  reg [31:0] ctrlQ, ampQ, cycleQ, pulseQ, biasQ, randQ, lenQ, freqQ, limQ;
  reg awHeld_q, wHeld_q, bValid_q, rValid_q;
  reg [7:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg [31:0] rData_q;
  reg [1:0] bResp_q, rResp_q;
  // Fields
  wire [1:0] ctrlSel = ctrlQ[1:0];
  wire [1:0] opSel = ctrlQ[3:2];
  wire [1:0] pulseSrc = ctrlQ[5:4];
  wire [7:0] swFunc = ctrlQ[15:8];
  wire [7:0] filtCnt = ctrlQ[23:16];
  wire [9:0] ampPct = ampQ[9:0];
  wire [9:0] recoilPct = ampQ[25:16];
  wire [15:0] cycleTenths = cycleQ[15:0];
  wire [9:0] riseCoef = cycleQ[25:16];
  wire [15:0] fullRate = pulseQ[15:0];
  wire [9:0] gainPct = pulseQ[25:16];
  wire signed [10:0] biasPct = biasQ[10:0];
  wire [9:0] randMax = randQ[9:0];
  wire [9:0] randMin = randQ[25:16];
  wire [9:0] lenMult = lenQ[25:16];
  wire [15:0] stopLen = lenQ[15:0];
  wire [15:0] setFreq = freqQ[15:0];
  wire [15:0] secFreq = freqQ[31:16];
  wire [15:0] maxFreq = limQ[15:0];
  wire [7:0] upperPct = limQ[23:16];
  wire [7:0] lowerPct = limQ[31:24];
  // ****************************************************
  // AXI4-Lite slave
  // ****************************************************
  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire awHave = awHeld_q || awTake;
  wire wHave = wHeld_q || wTake;
  wire [7:0] wa = awHeld_q ? awAddr_q : s_axi_awaddr;
  wire [31:0] wd = wHeld_q ? wData_q : s_axi_wdata;
  wire [3:0] ws = wHeld_q ? wStrb_q : s_axi_wstrb;
  wire doWrite = awHave && wHave && !bValid_q;
  reg [31:0] lenCnt_q;
  reg [15:0] outFreq_q, pulseF_q;
  reg active_q;
  wire [31:0] dispVal;
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bValid_q <= 1'b0;
      rValid_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      rData_q <= 32'h00000000;
      bResp_q <= 2'h0;
      rResp_q <= 2'h0;
      ctrlQ <= {8'h00, `TWFG_RST_FILT, 16'h0000};
      ampQ <= 32'h00000000;
      cycleQ <= 32'h00000000;
      pulseQ <= {16'h03E8, `TWFG_RST_RATE};
      biasQ <= 32'h00000000;
      randQ <= 32'h00000000;
      lenQ <= 32'h00000000;
      freqQ <= 32'h00000000;
      limQ <= 32'h00641388;
    end
    else
    begin
      if (awTake && !wHave)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake && !awHave)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q <= 2'h0;
        if (wa == `TWFG_REG_CTRL)
          ctrlQ <= mergeStrb(ctrlQ, wd, ws);
        else if (wa == `TWFG_REG_AMP)
          ampQ <= mergeStrb(ampQ, wd, ws);
        else if (wa == `TWFG_REG_CYCLE)
          cycleQ <= mergeStrb(cycleQ, wd, ws);
        else if (wa == `TWFG_REG_PULSE)
          pulseQ <= mergeStrb(pulseQ, wd, ws);
        else if (wa == `TWFG_REG_BIAS)
          biasQ <= mergeStrb(biasQ, wd, ws);
        else if (wa == `TWFG_REG_RAND)
          randQ <= mergeStrb(randQ, wd, ws);
        else if (wa == `TWFG_REG_LEN)
          lenQ <= mergeStrb(lenQ, wd, ws);
        else if (wa == `TWFG_REG_FREQ)
          freqQ <= mergeStrb(freqQ, wd, ws);
        else if (wa == `TWFG_REG_LIMIT)
          limQ <= mergeStrb(limQ, wd, ws);
        else
          bResp_q <= 2'h2;
      end
      else if (bValid_q && s_axi_bready)
        bValid_q <= 1'b0;
      if (s_axi_arvalid && !rValid_q)
      begin
        rValid_q <= 1'b1;
        rResp_q <= 2'h0;
        if (s_axi_araddr == `TWFG_REG_CTRL)
          rData_q <= ctrlQ;
        else if (s_axi_araddr == `TWFG_REG_AMP)
          rData_q <= ampQ;
        else if (s_axi_araddr == `TWFG_REG_CYCLE)
          rData_q <= cycleQ;
        else if (s_axi_araddr == `TWFG_REG_PULSE)
          rData_q <= pulseQ;
        else if (s_axi_araddr == `TWFG_REG_BIAS)
          rData_q <= biasQ;
        else if (s_axi_araddr == `TWFG_REG_RAND)
          rData_q <= randQ;
        else if (s_axi_araddr == `TWFG_REG_LEN)
          rData_q <= lenQ;
        else if (s_axi_araddr == `TWFG_REG_FREQ)
          rData_q <= freqQ;
        else if (s_axi_araddr == `TWFG_REG_LIMIT)
          rData_q <= limQ;
        else if (s_axi_araddr == `TWFG_REG_OUTF)
          rData_q <= {pulseF_q, outFreq_q};
        else if (s_axi_araddr == `TWFG_REG_LENST)
          rData_q <= {active_q, lenCnt_q[30:0]};
        else if (s_axi_araddr == `TWFG_REG_DISP)
          rData_q <= dispVal;
        else
        begin
          rData_q <= 32'h00000000;
          rResp_q <= 2'h2;
        end
      end
      else if (rValid_q && s_axi_rready)
        rValid_q <= 1'b0;
    end
  end
  // ****************************************************
  // Time base, random source, length count
  // ****************************************************
  reg [15:0] tick_q;
  reg [15:0] lfsr_q;
  reg sw_q, pin_q;
  wire tick = (tick_q == 16'h0000);
  wire [31:0] tickLoad = `TWFG_TICK_CYC - 32'h00000001;
  wire swRise = firstInputSwitch && !sw_q;
  wire pinRise = pulseIn && !pin_q;
  wire lenCount = (ctrlSel == `TWFG_CTRL_SETF || ctrlSel == `TWFG_CTRL_MAXF)
    && swFunc == `TWFG_SWFN_LENGTH;
  wire [31:0] stopPulses = stopLen * 32'h000003E8 * `TWFG_PULSES_PER_M;
  wire reached = (stopLen != 16'h0000) && (lenCnt_q >= stopPulses);
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_q <= 16'h0000;
      lfsr_q <= 16'hACE1;
      sw_q <= 1'b0;
      pin_q <= 1'b0;
      lenCnt_q <= 32'h00000000;
      active_q <= 1'b0;
    end
    else
    begin
      tick_q <= tick ? tickLoad[15:0] : tick_q - 16'h0001;
      lfsr_q <= {lfsr_q[14:0],
        lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      sw_q <= firstInputSwitch;
      pin_q <= pulseIn;
      // Length in 0.001 m per pulse times multiplier
      if (lenCount && swRise && !reached)
        lenCnt_q <= lenCnt_q + {22'h000000, lenMult};
      // Zero stop length never stops the mode
      active_q <= (ctrlSel != `TWFG_CTRL_OFF) && !reached;
    end
  end
  // Stop length display: plain below 10000 m, else code 3 and tens of
  // metres shown with three decimals; the 16-bit field never reaches
  // the two-decimal range
  wire [15:0] dispTens = stopLen / 16'h000A;
  assign dispVal = (stopLen < 16'h2710) ? {16'h0000, stopLen} :
    {14'h0000, 2'h3, dispTens};
  // ****************************************************
  // Base frequency and amplitude
  // ****************************************************
  wire twoPt = opSel[`TWFG_OP_TWOPT_BIT] && (stopLen != 16'h0000);
  wire randOn = opSel[`TWFG_OP_RAND_BIT];
  wire [31:0] lenFrac = (stopPulses == 0) ? 32'h0 :
    ((lenCnt_q >= stopPulses) ? 32'h3E8 : (lenCnt_q * 32'h3E8) / stopPulses);
  wire signed [17:0] fDiff = $signed({2'b00, secFreq}) - $signed({2'b00, setFreq});
  wire signed [28:0] fMove = fDiff * $signed({1'b0, lenFrac[10:0]});
  wire signed [28:0] baseWide = $signed({13'h0000, setFreq}) +
    fMove / 29'sh00003E8;
  wire [15:0] baseFreq = twoPt ? baseWide[15:0] : setFreq;
  wire [15:0] ampHz = (ctrlSel == `TWFG_CTRL_SETF) ? pctOf(baseFreq, ampPct)
    : pctOf(maxFreq, ampPct);
  wire [15:0] recoilHz = pctOf(ampHz, recoilPct);
  // ****************************************************
  // Triangle generator
  // ****************************************************
  localparam ST_RISE = 2'b01;
  localparam ST_FALL = 2'b10;
  reg [1:0] st_q;
  reg [31:0] phase_q;
  reg [9:0] riseUse_q;
  reg signed [17:0] offs_q;
  // Cycle time in 0.1 s, ticks are 1 ms
  wire [31:0] cycTicks = cycleTenths * 32'h64;
  wire [31:0] riseT = (cycTicks * riseUse_q) / `TWFG_PCT_FULL;
  wire [31:0] fallT = (cycTicks * (10'h3E8 - riseUse_q)) / `TWFG_PCT_FULL;
  wire [9:0] span = (randMax > randMin) ? randMax - randMin : 10'h000;
  wire [9:0] randPick = randMin + ((span == 0) ? 10'h0 : (lfsr_q[9:0] % (span + 10'h1)));
  wire signed [17:0] ampS = $signed({2'b00, ampHz});
  wire signed [17:0] recS = $signed({2'b00, recoilHz});
  wire [31:0] tFull = (st_q == ST_RISE) ? riseT : fallT;
  wire signed [49:0] ramp = (ampS * 18'sd2) * $signed({1'b0, phase_q[30:0]});
  wire signed [49:0] rampDiv = ramp / $signed({1'b0, tFull});
  wire signed [17:0] rampOff = (tFull == 32'h0) ? 18'sh0 : rampDiv[17:0];
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= ST_RISE;
      phase_q <= 32'h0;
      riseUse_q <= 10'h000;
      offs_q <= 18'sd0;
    end
    else if (!active_q)
    begin
      st_q <= ST_RISE;
      phase_q <= 32'h0;
      offs_q <= 18'sd0;
      riseUse_q <= riseCoef;
    end
    else if (tick)
    begin
      case (st_q)
        ST_RISE:
        begin
          offs_q <= -ampS + rampOff;
          if (phase_q + 1 >= riseT)
          begin
            st_q <= ST_FALL;
            phase_q <= 32'h0;
            offs_q <= ampS - recS;
          end
          else
            phase_q <= phase_q + 32'h1;
        end
        ST_FALL:
        begin
          offs_q <= ampS - rampOff;
          if (phase_q + 1 >= fallT)
          begin
            st_q <= ST_RISE;
            phase_q <= 32'h0;
            offs_q <= -ampS + recS;
            riseUse_q <= randOn ? randPick : riseCoef;
          end
          else
            phase_q <= phase_q + 32'h1;
        end
        default:
          st_q <= ST_RISE;
      endcase
    end
  end
  wire signed [18:0] windSum = $signed({3'b000, baseFreq}) + offs_q;
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      outFreq_q <= 16'h0000;
    else if (!active_q)
      outFreq_q <= setFreq;
    else
      outFreq_q <= windSum[18] ? 16'h0000 : windSum[15:0];
  end
  // ****************************************************
  // Pulse-train frequency input
  // ****************************************************
  reg [15:0] msCnt_q, hzAcc_q, rate_q;
  reg [23:0] filtAcc_q;
  reg [7:0] nSamp_q;
  reg [15:0] filtRate_q;
  wire [23:0] filtAvg = (filtAcc_q + {8'h00, hzAcc_q}) / {16'h0000, filtCnt};
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      msCnt_q <= 16'h0;
      hzAcc_q <= 16'h0;
      rate_q <= 16'h0;
      filtAcc_q <= 24'h0;
      nSamp_q <= 8'h0;
      filtRate_q <= 16'h0;
    end
    else
    begin
      if (tick && msCnt_q == 16'd999)
      begin
        msCnt_q <= 16'h0;
        hzAcc_q <= {15'h0, pinRise};
        rate_q <= hzAcc_q;
        filtAcc_q <= filtAcc_q + {8'h00, hzAcc_q};
        nSamp_q <= nSamp_q + 8'h01;
        if (nSamp_q + 8'h01 >= filtCnt)
        begin
          filtRate_q <= filtAvg[15:0];
          filtAcc_q <= 24'h0;
          nSamp_q <= 8'h0;
        end
      end
      else
      begin
        if (tick)
          msCnt_q <= msCnt_q + 16'h1;
        if (pinRise)
          hzAcc_q <= hzAcc_q + 16'h1;
      end
    end
  end
  // Full-scale rate maps to maximum frequency
  wire [31:0] rawF = (fullRate == 0) ? 32'h0 :
    (filtRate_q * maxFreq) / fullRate;
  wire signed [33:0] gainF = $signed({2'b00, rawF}) * $signed({1'b0, gainPct}) / 34'sd1000;
  wire signed [33:0] biasF = $signed({18'h0, maxFreq}) * biasPct / 34'sd1000;
  wire signed [33:0] sumF = gainF + biasF;
  wire [15:0] upF = pctOf(maxFreq, tenths(upperPct));
  wire [15:0] loF = pctOf(maxFreq, tenths(lowerPct));
  wire [15:0] capF = (upF < maxFreq) ? upF : maxFreq;
  wire [15:0] posF = sumF[33] ? 16'h0 :
    (sumF > $signed({18'h0, capF}) ? capF : sumF[15:0]);
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      pulseF_q <= 16'h0000;
    else if (pulseSrc == `TWFG_PSRC_PULSE)
      pulseF_q <= (posF < loF) ? loF : posF;
    else
      pulseF_q <= 16'h0000;
  end
  assign windFreqOut = outFreq_q;
  assign pulseFreqOut = pulseF_q;
  assign windingActive = active_q;
endmodule // twfg_traverse_winding_freq_gen

// >>> dv/twfg_chk.sv
// Bus and output checker for the traverse winding frequency generator
`timescale 1ns/10ps
module twfg_chk
(
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // Read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Outputs
  input wire [15:0] windFreqOut,
  input wire [15:0] pulseFreqOut,
  input wire windingActive
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_bvalid_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  a_rdata_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=>
                     s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response changed before rready");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                     s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while response pending");
  a_rd_unmapped:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2C
                     |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_wr_unmapped:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                     s_axi_wready && s_axi_awaddr > 8'h2C
                     |=> s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  a_rd_mapped:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h2C
                     && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  a_reset_zero:
    assert property ($rose(rst_b) |-> windFreqOut == 16'h0 &&
                     pulseFreqOut == 16'h0 && !windingActive)
    else $error("outputs not cleared by reset");
endmodule // twfg_chk

bind twfg_traverse_winding_freq_gen twfg_chk u_chk (.*);

// >>> dv/twfg_pulse_src.sv
// Pulse train and length switch source beside the generator
`timescale 1ns/10ps
module twfg_pulse_src
#(
  parameter int HALF_PERIOD = 2500
)
(
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Bench control
  input wire lenGo,
  // Pulse outputs
  output logic pulseIn,
  output logic firstInputSwitch
);
  logic [11:0] divQ;
  // Pulse train near full scale, switch pulses only while asked
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divQ <= 12'h0;
      pulseIn <= 1'b0;
      firstInputSwitch <= 1'b0;
    end
    else
    begin
      divQ <= (divQ == HALF_PERIOD - 1) ? 12'h0 : divQ + 12'h1;
      if (divQ == 12'h0)
        pulseIn <= ~pulseIn;
      if (!lenGo)
        firstInputSwitch <= 1'b0;
      else if (divQ[2:0] == 3'h0)
        firstInputSwitch <= ~firstInputSwitch;
    end
  end
endmodule // twfg_pulse_src

// >>> dv/tb_traverse_winding_freq_gen.sv
// Self-checking testbench for the traverse winding frequency generator
`timescale 1ns/10ps
module tb_traverse_winding_freq_gen;
  logic mclk, rst_b, lenGo, pulseIn, firstInputSwitch;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, v0;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, windingActive;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] windFreqOut, pulseFreqOut;
  int n_fail, cmp_count;

  twfg_traverse_winding_freq_gen u_dut (.*);
  twfg_pulse_src u_src (.mclk(mclk), .rst_b(rst_b), .lenGo(lenGo),
    .pulseIn(pulseIn), .firstInputSwitch(firstInputSwitch));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ****************************************
  // Bus tasks
  // ****************************************
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic aR, wR, got;
    n = 0;
    got = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got && n < 200)
    begin
      @(negedge mclk);
      aR = s_axi_awvalid && s_axi_awready;
      wR = s_axi_wvalid && s_axi_wready;
      got = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge mclk);
      if (aR)
        s_axi_awvalid <= 1'b0;
      if (wR)
        s_axi_wvalid <= 1'b0;
      if (got)
        s_axi_bready <= 1'b0;
      n++;
    end
    if (!got)
    begin
      n_fail++;
      final_report();
    end
  endtask

  task rdt(input logic [7:0] a);
    int n;
    logic aR, got;
    n = 0;
    got = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got && n < 200)
    begin
      @(negedge mclk);
      aR = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge mclk);
      if (aR)
        s_axi_arvalid <= 1'b0;
      if (got)
        s_axi_rready <= 1'b0;
      n++;
    end
    if (!got)
    begin
      n_fail++;
      final_report();
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    chk({windingActive, windFreqOut}, 32'h0);
    rdt(8'h00);
    chk(rd, 32'h000A0000);
    rdt(8'h0C);
    chk(rd, 32'h03E82710);
    $display("test reset done");
  endtask

  task t_regs();
    int k;
    wr(8'h04, 32'h00C801F4, 4'hF);
    wr(8'h04, 32'h000000FF, 4'h1);
    rdt(8'h04);
    chk(rd, 32'h00C801FF);
    wr(8'h10, 32'h00000422, 4'hF);
    rdt(8'h10);
    chk(rd, 32'h00000422);
    for (k = 0; k < 4; k++)
    begin
      wr(8'h00, 32'h000A0000 | (k << 2), 4'hF);
      rdt(8'h00);
      chk(rd, 32'h000A0000 | (k << 2));
    end
    $display("test registers done");
  endtask

  task t_err();
    wr(8'h40, 32'h12345678, 4'hF);
    chk({30'h0, rs}, 32'h2);
    rdt(8'h40);
    chk({rs, rd[29:0]}, 32'h80000000);
    $display("test unmapped done");
  endtask

  task t_off();
    wr(8'h1C, 32'h0FA01388, 4'hF);
    wr(8'h00, 32'h000A0000, 4'hF);
    // Swing off reloads the setting every cycle
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk({16'h0, windFreqOut}, 32'h1388);
    rdt(8'h24);
    chk({16'h0, rd[15:0]}, 32'h1388);
    $display("test swing off done");
  endtask

  task t_len();
    wr(8'h18, 32'h03E80000, 4'hF);
    wr(8'h00, 32'h000A0E01, 4'hF);
    rdt(8'h28);
    v0 = rd;
    lenGo <= 1'b1;
    repeat (160) @(posedge mclk);
    lenGo <= 1'b0;
    repeat (4) @(posedge mclk);
    rdt(8'h28);
    chk({31'h0, rd !== v0}, 32'h1);
    chk(rd[30:0] % 32'h3E8, 32'h0);
    chk({31'h0, windingActive}, 32'h1);
    $display("test length done");
  endtask

  task settle();
    repeat (2) @(negedge mclk);
  endtask

  task t_pulse();
    wr(8'h00, 32'h000A0020, 4'hF);
    wr(8'h10, 32'h000000C8, 4'hF);
    settle();
    chk({16'h0, pulseFreqOut}, 32'h3E8);
    wr(8'h10, 32'h0000079C, 4'hF);
    settle();
    chk({16'h0, pulseFreqOut}, 32'h0);
    wr(8'h20, 32'h1E641388, 4'hF);
    settle();
    chk({16'h0, pulseFreqOut}, 32'h5DC);
    wr(8'h20, 32'h00321388, 4'hF);
    wr(8'h10, 32'h000003E8, 4'hF);
    settle();
    chk({16'h0, pulseFreqOut}, 32'h9C4);
    $display("test pulse input done");
  endtask

  task t_swing();
    int n;
    n = 0;
    wr(8'h00, 32'h000A0000, 4'hF);
    wr(8'h04, 32'h00C80064, 4'hF);
    wr(8'h00, 32'h000A0001, 4'hF);
    // First turnaround comes on the next millisecond tick
    while (windFreqOut == 16'h1388 && n < 60000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 60000)
    begin
      n_fail++;
      final_report();
    end
    chk({16'h0, windFreqOut}, 32'h1518);
    $display("test swing done");
  endtask

  task t_stop();
    wr(8'h18, 32'h03E83039, 4'hF);
    rdt(8'h2C);
    chk(rd, 32'h000304D2);
    wr(8'h18, 32'h03E80005, 4'hF);
    settle();
    chk({15'h0, windingActive, windFreqOut}, 32'h1388);
    $display("test stop length done");
  endtask

  initial
  begin
    n_fail = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    lenGo = 1'b0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_err();
    t_off();
    t_pulse();
    t_len();
    t_swing();
    t_stop();
    final_report();
  end
endmodule // tb_traverse_winding_freq_gen
